/* File: src/epsp_pkg.sv */
// Constants, types and variant defaults for the encoder position scaling block.
package epsp_pkg;

  // Encoder variants that can be built.
  typedef enum logic [1:0] {
    VAR_EM = 2'h0,
    VAR_HS = 2'h1,
    VAR_HM = 2'h2
  } epsp_variant_type;

  // Variant physical resolutions; these are also the reset defaults of the custom settings.
  localparam logic [31:0] EM_SPT    = 32'h0000_2000;
  localparam logic [31:0] EM_TOTAL  = 32'h0800_0000;
  localparam logic [31:0] EM_TURNS  = 32'h0000_4000;
  localparam logic [31:0] HS_SPT    = 32'h0004_0000;
  localparam logic [31:0] HS_TOTAL  = 32'h0004_0000;
  localparam logic [31:0] HS_TURNS  = 32'h0000_0001;
  localparam logic [31:0] HM_SPT    = 32'h0001_0000;
  localparam logic [31:0] HM_TOTAL  = 32'h4000_0000;
  localparam logic [31:0] HM_TURNS  = 32'h0000_4000;
  localparam logic [31:0] MAX_TURNS = 32'h0000_4000;

  // Configuration and status word layout.
  localparam int          CFG_DIR_BIT   = 0;
  localparam int          CFG_SCALE_BIT = 2;
  localparam logic [15:0] CFG_MASK      = 16'h0005;
  localparam logic [15:0] CFG_RESET     = 16'h0000;
  localparam logic [31:0] PRESET_RESET  = 32'h0000_0000;
  localparam logic [31:0] OFFSET_RESET  = 32'h0000_0000;

  // Divider step count for a 64-bit dividend.
  localparam logic [6:0] DIV_STEPS = 7'h40;

  // Object selected by a configuration write.
  typedef enum logic [3:0] {
    OBJ_CFG    = 4'h1,
    OBJ_SPT    = 4'h2,
    OBJ_TOTAL  = 4'h4,
    OBJ_PRESET = 4'h8
  } epsp_obj_type;

  // One configuration write from the fieldbus side.
  typedef struct packed {
    logic         wr;
    epsp_obj_type obj;
    logic [31:0]  data;
  } epsp_od_wr_type;

  // Position pipeline states.
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_TURN  = 4'h2,
    ST_SCALE = 4'h4,
    ST_WRAP  = 4'h8
  } epsp_state_type;

  // Physical steps per turn of a variant.
  function automatic logic [31:0] def_spt(epsp_variant_type v);
    logic [31:0] r;
    r = HM_SPT;
    if (v == VAR_EM) r = EM_SPT;
    if (v == VAR_HS) r = HS_SPT;
    return r;
  endfunction

  // Default total range of a variant.
  function automatic logic [31:0] def_total(epsp_variant_type v);
    logic [31:0] r;
    r = HM_TOTAL;
    if (v == VAR_EM) r = EM_TOTAL;
    if (v == VAR_HS) r = HS_TOTAL;
    return r;
  endfunction

  // Physical turn count of a variant.
  function automatic logic [31:0] def_turns(epsp_variant_type v);
    logic [31:0] r;
    r = HM_TURNS;
    if (v == VAR_EM) r = EM_TURNS;
    if (v == VAR_HS) r = HS_TURNS;
    return r;
  endfunction

endpackage

/* File: src/epsp_div.sv */
// Sequential restoring divider, 64-bit dividend by 32-bit divisor.
module epsp_div (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic [63:0] num,
  input  wire logic [31:0] den,
  output logic             done,
  output logic [63:0]      quo,
  output logic [31:0]      rem
);

  logic [63:0] quo_reg;
  logic [63:0] quo_next;
  logic [32:0] rem_reg;
  logic [32:0] rem_next;
  logic [31:0] den_reg;
  logic [31:0] den_next;
  logic [6:0]  cnt_reg;
  logic [6:0]  cnt_next;
  logic        done_reg;
  logic        done_next;
  logic [32:0] shifted;
  logic        fits;

  // One quotient bit per cycle; a fresh start aborts any division in flight.
  always_comb begin
    quo_next  = quo_reg;
    rem_next  = rem_reg;
    den_next  = den_reg;
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    shifted   = {rem_reg[31:0], quo_reg[63]};
    fits      = shifted >= {1'b0, den_reg};
    if (start) begin
      quo_next = num;
      rem_next = 33'h0_0000_0000;
      den_next = den;
      cnt_next = epsp_pkg::DIV_STEPS;
    end else if (cnt_reg != 7'h00) begin
      rem_next  = fits ? shifted - {1'b0, den_reg} : shifted;
      quo_next  = {quo_reg[62:0], fits};
      cnt_next  = cnt_reg - 7'h01;
      done_next = cnt_reg == 7'h01;
    end
  end

  // Registers only.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      quo_reg  <= 64'h0000_0000_0000_0000;
      rem_reg  <= 33'h0_0000_0000;
      den_reg  <= 32'h0000_0000;
      cnt_reg  <= 7'h00;
      done_reg <= 1'b0;
    end else begin
      quo_reg  <= quo_next;
      rem_reg  <= rem_next;
      den_reg  <= den_next;
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;
  assign quo  = quo_reg;
  assign rem  = rem_reg[31:0];

endmodule

/* File: src/epsp_top.sv */
// Position scaling, plausibility check and preset for an absolute rotary encoder.
//
// Notes on behaviour
// - A writable 32-bit custom steps-per-turn value is held.
// - With scaling off, position is the physical count; custom values are ignored.
// - Custom steps per turn resets to the variant default.
// - Implied turn count is total range divided by steps per turn.
// - Total range below steps per turn is invalid and flagged.
// - Implied turns above the hardware capacity, at most 16384, raise a fault.
// - Inconsistent scaled settings report a wrong-parametrization status.
// - Non power-of-two turn counts make the scaled count jump before physical zero.
// - Custom total range resets to the variant default.
// - A preset gives the current position the written value, shifting all others.
// - Status word mirrors the scaling enable bit at the same position.
// - Executing a preset stores the current position as the offset.
// - Output is read position plus preset value minus offset.
module epsp_top #(
  parameter epsp_pkg::epsp_variant_type VARIANT = epsp_pkg::VAR_HM
) (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire epsp_pkg::epsp_od_wr_type od_wr,
  input  wire logic                     preset_exec,
  input  wire logic [31:0]              phys_pos,
  output logic [15:0]                   cfg_word,
  output logic [15:0]                   status_word,
  output logic [31:0]                   custom_steps_per_turn,
  output logic [31:0]                   custom_total_range,
  output logic [31:0]                   preset_value,
  output logic [31:0]                   offset_value,
  output logic [31:0]                   position_value,
  output logic                          param_fault
);

  localparam logic [31:0] HW_SPT   = epsp_pkg::def_spt(VARIANT);
  localparam logic [31:0] HW_TURNS = epsp_pkg::def_turns(VARIANT);
  localparam logic [31:0] DEF_TOT  = epsp_pkg::def_total(VARIANT);
  localparam logic [63:0] HW_TOTAL = {32'h0000_0000, HW_SPT} * {32'h0000_0000, HW_TURNS};
  localparam logic [31:0] TURN_CAP = (HW_TURNS > epsp_pkg::MAX_TURNS) ? epsp_pkg::MAX_TURNS : HW_TURNS;

  logic [15:0]              cfg_reg;
  logic [15:0]              cfg_next;
  logic [15:0]              status_reg;
  logic [15:0]              status_next;
  logic [31:0]              spt_reg;
  logic [31:0]              spt_next;
  logic [31:0]              total_reg;
  logic [31:0]              total_next;
  logic [31:0]              preset_reg;
  logic [31:0]              preset_next;
  logic [31:0]              offset_reg;
  logic [31:0]              offset_next;
  logic [31:0]              pos_reg;
  logic [31:0]              pos_next;
  logic [31:0]              read_reg;
  logic [31:0]              read_next;
  logic [31:0]              phys_reg;
  logic [31:0]              phys_next;
  logic                     fault_reg;
  logic                     fault_next;
  epsp_pkg::epsp_state_type state_reg;
  epsp_pkg::epsp_state_type state_next;
  logic                     scale_en;
  logic                     bad_cfg;
  logic                     div_start;
  logic [63:0]              div_num;
  logic [31:0]              div_den;
  logic                     div_done;
  logic [63:0]              div_quo;
  logic [31:0]              div_rem;

  assign scale_en = cfg_reg[epsp_pkg::CFG_SCALE_BIT];

  // Settings that are wrong before any division; a zero divisor is caught here too.
  assign bad_cfg = (spt_reg == 32'h0000_0000) || (spt_reg > HW_SPT)
                 || (total_reg < spt_reg)
                 || ({32'h0000_0000, total_reg} > HW_TOTAL);

  // Configuration writes, status mirror, preset offset and the transmitted value.
  always_comb begin
    cfg_next    = cfg_reg;
    spt_next    = spt_reg;
    total_next  = total_reg;
    preset_next = preset_reg;
    if (od_wr.wr) begin
      unique case (od_wr.obj)
        epsp_pkg::OBJ_CFG:    cfg_next = od_wr.data[15:0] & epsp_pkg::CFG_MASK;
        epsp_pkg::OBJ_SPT:    spt_next = od_wr.data;
        epsp_pkg::OBJ_TOTAL:  total_next = od_wr.data;
        epsp_pkg::OBJ_PRESET: preset_next = od_wr.data;
        default:              cfg_next = cfg_reg;
      endcase
    end
    status_next = cfg_reg & epsp_pkg::CFG_MASK;
    offset_next = preset_exec ? read_reg : offset_reg;
    pos_next    = read_reg + preset_reg - offset_reg;
  end

  // Position pipeline: turn check, multiply-divide, then wrap; one shared divider.
  always_comb begin
    state_next = state_reg;
    read_next  = read_reg;
    phys_next  = phys_reg;
    fault_next = fault_reg;
    div_start  = 1'b0;
    div_num    = 64'h0000_0000_0000_0000;
    div_den    = 32'h0000_0000;
    unique case (state_reg)
      epsp_pkg::ST_IDLE: begin
        phys_next = phys_pos;
        if (!scale_en) begin
          read_next  = phys_pos;
          fault_next = 1'b0;
        end else if (bad_cfg) begin
          fault_next = 1'b1;
        end else begin
          div_start  = 1'b1;
          div_num    = {32'h0000_0000, total_reg};
          div_den    = spt_reg;
          state_next = epsp_pkg::ST_TURN;
        end
      end
      epsp_pkg::ST_TURN: begin
        if (div_done) begin
          if (div_quo > {32'h0000_0000, TURN_CAP}) begin
            fault_next = 1'b1;
            state_next = epsp_pkg::ST_IDLE;
          end else begin
            div_start  = 1'b1;
            div_num    = {32'h0000_0000, phys_reg} * {32'h0000_0000, spt_reg};
            div_den    = HW_SPT;
            state_next = epsp_pkg::ST_SCALE;
          end
        end
      end
      epsp_pkg::ST_SCALE: begin
        if (div_done) begin
          div_start  = 1'b1;
          div_num    = div_quo;
          div_den    = total_reg;
          state_next = epsp_pkg::ST_WRAP;
        end
      end
      epsp_pkg::ST_WRAP: begin
        if (div_done) begin
          // The wrap point is the total range, so a non power-of-two turn count jumps early.
          read_next  = div_rem;
          fault_next = 1'b0;
          state_next = epsp_pkg::ST_IDLE;
        end
      end
      default: state_next = epsp_pkg::ST_IDLE;
    endcase
    // A settings write during a pass restarts it; one in the ST_IDLE cycle that starts a pass does not, so that pass mixes old and new settings.
    if (od_wr.wr && od_wr.obj != epsp_pkg::OBJ_PRESET && state_reg != epsp_pkg::ST_IDLE) begin
      state_next = epsp_pkg::ST_IDLE;
    end
  end

  epsp_div u_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (div_start),
    .num     (div_num),
    .den     (div_den),
    .done    (div_done),
    .quo     (div_quo),
    .rem     (div_rem)
  );

  // Registers only; custom settings come up at the variant defaults.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_reg    <= epsp_pkg::CFG_RESET;
      status_reg <= epsp_pkg::CFG_RESET;
      spt_reg    <= HW_SPT;
      total_reg  <= DEF_TOT;
      preset_reg <= epsp_pkg::PRESET_RESET;
      offset_reg <= epsp_pkg::OFFSET_RESET;
      pos_reg    <= 32'h0000_0000;
      read_reg   <= 32'h0000_0000;
      phys_reg   <= 32'h0000_0000;
      fault_reg  <= 1'b0;
      state_reg  <= epsp_pkg::ST_IDLE;
    end else begin
      cfg_reg    <= cfg_next;
      status_reg <= status_next;
      spt_reg    <= spt_next;
      total_reg  <= total_next;
      preset_reg <= preset_next;
      offset_reg <= offset_next;
      pos_reg    <= pos_next;
      read_reg   <= read_next;
      phys_reg   <= phys_next;
      fault_reg  <= fault_next;
      state_reg  <= state_next;
    end
  end

  assign cfg_word              = cfg_reg;
  assign status_word           = status_reg;
  assign custom_steps_per_turn = spt_reg;
  assign custom_total_range    = total_reg;
  assign preset_value          = preset_reg;
  assign offset_value          = offset_reg;
  assign position_value        = pos_reg;
  assign param_fault           = fault_reg;

  // Last step of a successful scaled pass.
  sequence s_wrap_done;
    state_reg == epsp_pkg::ST_WRAP && div_done;
  endsequence

  sequence s_bad_seen;
    scale_en && (total_reg < spt_reg) && state_reg == epsp_pkg::ST_IDLE;
  endsequence

  property p_spt_write;
    @(posedge clk) disable iff (sys_rst)
      od_wr.wr && od_wr.obj == epsp_pkg::OBJ_SPT |=> spt_reg == $past(od_wr.data);
  endproperty
  a_spt_write: assert property (p_spt_write) else $error("Steps per turn not stored.");

  property p_unscaled;
    @(posedge clk) disable iff (sys_rst)
      state_reg == epsp_pkg::ST_IDLE && !scale_en |=> read_reg == $past(phys_pos)
        ##1 position_value == $past(phys_pos, 2) + $past(preset_reg) - $past(offset_reg);
  endproperty
  a_unscaled: assert property (p_unscaled) else $error("Unscaled position wrong.");

  property p_defaults;
    @(posedge clk) disable iff (sys_rst)
      $fell(sys_rst) |-> spt_reg == HW_SPT && total_reg == DEF_TOT;
  endproperty
  a_defaults: assert property (p_defaults) else $error("Reset defaults wrong.");

  property p_range_low;
    @(posedge clk) disable iff (sys_rst)
      s_bad_seen |=> param_fault;
  endproperty
  a_range_low: assert property (p_range_low) else $error("Short total range not flagged.");

  property p_turn_cap;
    @(posedge clk) disable iff (sys_rst)
      state_reg == epsp_pkg::ST_TURN && div_done && div_quo > {32'h0000_0000, TURN_CAP}
      |=> param_fault && state_reg == epsp_pkg::ST_IDLE;
  endproperty
  a_turn_cap: assert property (p_turn_cap) else $error("Turn overflow not flagged.");

  property p_fault_clear;
    @(posedge clk) disable iff (sys_rst)
      s_wrap_done |=> !param_fault;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("Fault kept after good pass.");

  property p_status;
    @(posedge clk) disable iff (sys_rst)
      ##1 status_word[epsp_pkg::CFG_SCALE_BIT] == $past(cfg_reg[epsp_pkg::CFG_SCALE_BIT]);
  endproperty
  a_status: assert property (p_status) else $error("Status scaling bit wrong.");

  property p_offset;
    @(posedge clk) disable iff (sys_rst)
      preset_exec |=> offset_value == $past(read_reg)
        ##1 position_value == $past(preset_reg) + $past(read_reg) - $past(read_reg, 2);
  endproperty
  a_offset: assert property (p_offset) else $error("Preset offset wrong.");

  property p_output;
    @(posedge clk) disable iff (sys_rst)
      ##1 position_value == $past(read_reg) + $past(preset_reg) - $past(offset_reg);
  endproperty
  a_output: assert property (p_output) else $error("Transmitted position wrong.");

  property p_wrap;
    @(posedge clk) disable iff (sys_rst)
      s_wrap_done |=> read_reg < total_reg || !$stable(total_reg);
  endproperty
  a_wrap: assert property (p_wrap) else $error("Scaled position not wrapped.");

endmodule

/* File: testbench/epsp_master_model.sv */
// Fieldbus master model that issues configuration writes and preset commands.
module epsp_master_model (
  input  wire logic                clk,
  output epsp_pkg::epsp_od_wr_type od_wr,
  output logic                     preset_exec
);
  timeunit 1ns;
  timeprecision 1ps;

  // The bus idles with filler data, so a stale word is never mistaken for a write.
  initial begin
    od_wr = '{wr: 1'b0, obj: epsp_pkg::OBJ_CFG, data: 32'hA5A5_5A5A};
    preset_exec = 1'b0;
  end

  // One write is a single-cycle strobe; data is inverted after it so nothing lingers.
  // Values pass as commanded: legal settings unless a scenario breaks them on purpose.
  task automatic write(input epsp_pkg::epsp_obj_type obj, input logic [31:0] data);
    @(negedge clk);
    od_wr = '{wr: 1'b1, obj: obj, data: data};
    @(negedge clk);
    od_wr.wr = 1'b0;
    od_wr.data = ~data;
  endtask

  // The caller keeps the shaft position still around the command.
  task automatic preset();
    @(negedge clk);
    preset_exec = 1'b1;
    @(negedge clk);
    preset_exec = 1'b0;
  endtask
endmodule

/* File: testbench/test_epsp_top.sv */
// Self-checking testbench for the encoder position scaling block.
module test_epsp_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {int sel; logic [31:0] val;} epsp_note_type;

  logic                     clk;
  logic                     sys_rst;
  epsp_pkg::epsp_od_wr_type od_wr;
  logic                     preset_exec;
  logic [31:0]              phys_pos;
  logic [15:0]              cfg_word;
  logic [15:0]              status_word;
  logic [31:0]              spt;
  logic [31:0]              total;
  logic [31:0]              preset_value;
  logic [31:0]              offset_value;
  logic [31:0]              position_value;
  logic                     param_fault;
  epsp_note_type            notes[$];
  int                       n_mismatch = 0;
  int                       samples_checked = 0;
  int                       cycles = 0;
  int                       seed;
  logic [31:0]              p;
  logic [31:0]              r;
  logic [63:0]              t;
  logic [31:0]              bad_spt[3] = '{32'h0000_0168, 32'h0000_0800, 32'h0002_0000};
  logic [31:0]              bad_tot[3] = '{32'h0200_0000, 32'h0000_0168, 32'h0002_0000};

  epsp_master_model m (.clk(clk), .od_wr(od_wr), .preset_exec(preset_exec));

  epsp_top dut_u (
    .clk                   (clk),
    .sys_rst               (sys_rst),
    .od_wr                 (od_wr),
    .preset_exec           (preset_exec),
    .phys_pos              (phys_pos),
    .cfg_word              (cfg_word),
    .status_word           (status_word),
    .custom_steps_per_turn (spt),
    .custom_total_range    (total),
    .preset_value          (preset_value),
    .offset_value          (offset_value),
    .position_value        (position_value),
    .param_fault           (param_fault)
  );

  // Free-running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Picks the output that a note refers to.
  function automatic logic [31:0] seen(int s);
    case (s)
      0: return spt;
      1: return total;
      2: return preset_value;
      3: return offset_value;
      4: return position_value;
      5: return {31'h0000_0000, param_fault};
      6: return {31'h0000_0000, status_word[2]};
      default: return {16'h0000, cfg_word};
    endcase
  endfunction

  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, s, e);
    end
  endtask

  // The driver records what it expects; the monitor below settles it.
  task automatic note(input int s, input logic [31:0] v);
    notes.push_back('{s, v});
  endtask

  // Shortly after each falling edge, outputs are settled and pending notes are compared.
  initial begin
    epsp_note_type n;
    forever begin
      @(negedge clk);
      #1;
      while (notes.size() > 0) begin
        n = notes.pop_front();
        check(seen(n.sel), n.val);
      end
    end
  end

  // Bounded wait for the fault flag to reach a level.
  task automatic wait_fault(input logic v);
    for (int i = 0; i < 600 && param_fault !== v; i++) @(negedge clk);
  endtask

  // Good scaled settings: 2048 steps over 1024 turns.
  task automatic good_scale();
    m.write(epsp_pkg::OBJ_SPT, 32'h0000_0800);
    m.write(epsp_pkg::OBJ_TOTAL, 32'h0020_0000);
  endtask

  // Verdict and end of run.
  task automatic end_sim();
    $display("checked %0d values, %0d mismatches", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // A hang is cut short well beyond the expected run length.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // Main sequence.
  initial begin
    seed = 96447;
    sys_rst = 1'b1;
    phys_pos = 32'h0000_0000;
    repeat (4) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    phys_pos = $random(seed);
    repeat (3) @(negedge clk);
    note(0, 32'h0001_0000);
    note(1, 32'h4000_0000);
    note(4, phys_pos);
    note(5, 32'h0000_0000);
    note(6, 32'h0000_0000);
    // Odd custom values are stored but ignored while scaling is off.
    r = $random(seed);
    m.write(epsp_pkg::OBJ_SPT, r);
    m.write(epsp_pkg::OBJ_TOTAL, 32'h0000_0003);
    note(0, r);
    note(1, 32'h0000_0003);
    @(negedge clk);
    note(4, phys_pos);
    // Preset at a still shaft, then one step forward.
    p = $random(seed);
    m.write(epsp_pkg::OBJ_PRESET, p);
    note(2, p);
    r = phys_pos;
    m.preset();
    repeat (2) @(negedge clk);
    note(3, r);
    note(4, p);
    phys_pos = phys_pos + 32'h0000_0001;
    repeat (3) @(negedge clk);
    note(4, p + 32'h0000_0001);
    // Enable scaling; only the direction and scaling bits are kept.
    m.write(epsp_pkg::OBJ_CFG, 32'hFFFF_FFFF);
    @(negedge clk);
    note(7, 32'h0000_0005);
    note(6, 32'h0000_0001);
    good_scale();
    repeat (500) @(negedge clk);
    note(5, 32'h0000_0000);
    t = ({32'h0000_0000, phys_pos} * 64'h0000_0000_0000_0800) / 64'h0000_0000_0001_0000;
    t = t % 64'h0000_0000_0020_0000;
    note(4, t[31:0] + p - r);
    // New preset for the new resolution.
    p = $random(seed) & 32'h001F_FFFF;
    m.write(epsp_pkg::OBJ_PRESET, p);
    m.preset();
    repeat (2) @(negedge clk);
    note(3, t[31:0]);
    note(4, p);
    r = t[31:0];
    // Turn overflow, range below steps per turn, steps above physical.
    for (int k = 0; k < 3; k++) begin
      good_scale();
      wait_fault(1'b0);
      note(5, 32'h0000_0000);
      m.write(epsp_pkg::OBJ_SPT, bad_spt[k]);
      m.write(epsp_pkg::OBJ_TOTAL, bad_tot[k]);
      wait_fault(1'b1);
      note(5, 32'h0000_0001);
    end
    // Disabling scaling clears the fault and returns to physical counting.
    m.write(epsp_pkg::OBJ_CFG, 32'h0000_0000);
    repeat (3) @(negedge clk);
    note(5, 32'h0000_0000);
    note(6, 32'h0000_0000);
    note(4, phys_pos + p - r);
    repeat (2) @(negedge clk);
    end_sim();
  end
endmodule
